//--- core/ofd_decode.sv
// Contract
// - Access bit zero uses access RAM; one takes bank from bank select.
// - Destination bit one writes byte result back to the file register.
// - Destination bit zero writes byte result to the working accumulator.
// - Three-bit index selects one bit 0..7 of the addressed register.
// - File field is 8-bit address, or 2-bit pointer selector for pointers.
// - Register moves carry full 12-bit source and destination, no banking.
// - Literal extracted at 8, 12 or 20 bits depending on instruction type.
// - Table mode picks keep, post-increment, post-decrement, pre-increment.
// - Relative offsets are two's complement; absolute targets used directly.
// - Fast bit one saves or restores shadows; zero leaves shadows alone.
// - Table pointer is 21 bits wide, table latch 8 bits wide.
// - Don't-care opcode bits never change the decoded result.
// - Access zero, extended set on, address up to 5Fh: indexed offset mode.
`timescale 1ns/10ps

module ofd_decode (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Fetch stage
   input wire logic [15:0] INSTR_WORD,
   input wire logic INSTR_VALID,
   input wire logic EXT_SET_EN,
   // Core state
   input wire logic [3:0] BANK_SELECT_REG,
   input wire logic [20:0] TBL_PTR_LOAD,
   input wire logic TBL_PTR_WR,
   input wire logic [7:0] TBL_LATCH_LOAD,
   input wire logic TBL_LATCH_WR,
   // Decoded fields
   output ofd_pkg::ofd_fields_t FIELDS,
   output logic FIELDS_VALID,
   // Table access state
   output logic [ofd_pkg::OFD_TABLE_POINTER_W-1:0] TABLE_POINTER,
   output logic [ofd_pkg::OFD_TBLLAT_W-1:0] TABLE_LATCH
);

   ////////////////////////////////////////////////////////////////////////
   // Second word tracking for two-word instructions

   logic second_q;
   logic second_d;
   logic [15:0] first_q;
   ofd_pkg::ofd_fields_t f_d;
   ofd_pkg::ofd_fields_t fields_q;
   logic valid_q;
   logic [20:0] tptr_q;
   logic [7:0] tlat_q;

   // Decodes the class from the upper opcode bits, plus low bits for table and return forms
   function automatic ofd_pkg::ofd_cls_t cls_of(input logic [15:0] w);
      ofd_pkg::ofd_cls_t c;
      c = ofd_pkg::OFD_CLS_NONE;
      if (w[15:12] == 4'hC)
         c = ofd_pkg::OFD_CLS_MOVFF;
      else if (w[15:12] == 4'hD)
         c = ofd_pkg::OFD_CLS_BRA_REL;
      else if (w[15:12] == 4'hE) begin
         if (w[11:8] == 4'hF || w[11:8] == 4'hC || w[11:8] == 4'hD)
            c = (w[11:8] == 4'hF) ? ofd_pkg::OFD_CLS_GOTO
              : ((w[11:8] == 4'hE) ? ofd_pkg::OFD_CLS_LFSR
              : ofd_pkg::OFD_CLS_CALL);
         else if (w[11:8] == 4'hE)
            c = ofd_pkg::OFD_CLS_LFSR;
         else
            c = ofd_pkg::OFD_CLS_BCC_REL;
      end
      else if (w[15:12] >= 4'h7 && w[15:12] <= 4'hB)
         c = ofd_pkg::OFD_CLS_BIT;
      else if (w[15:12] == 4'h0 && w[11:8] >= 4'h8)
         c = ofd_pkg::OFD_CLS_LIT8;
      else if (w[15:12] == 4'h0 && w[11:4] == 8'h00) begin
         if (w[3:2] == 2'h2)
            c = ofd_pkg::OFD_CLS_TBL_RD;
         else if (w[3:2] == 2'h3)
            c = ofd_pkg::OFD_CLS_TBL_WR;
         else if (w[3:1] == 3'h1 || w[3:1] == 3'h0)
            c = ofd_pkg::OFD_CLS_NONE;
      end
      else if (w[15:12] == 4'h0 && w[11:2] == 10'h004)
         c = ofd_pkg::OFD_CLS_RET;
      else if (w[15:12] != 4'h0 && w[15:12] <= 4'h6)
         c = ofd_pkg::OFD_CLS_BYTE;
      else if (w[15:12] == 4'h0 && w[11:8] == 4'h1)
         c = ofd_pkg::OFD_CLS_LIT8;
      cls_of = c;
   endfunction : cls_of

   // Banked or access address for byte and bit forms
   function automatic logic [11:0] bank_addr(input logic [15:0] w,
                                             input logic [3:0] bank_select_reg);
      if (w[ofd_pkg::OFD_POS_A])
         bank_addr = {bank_select_reg, w[7:0]};
      else if (w[7:0] < ofd_pkg::OFD_ACC_SPLIT)
         bank_addr = {ofd_pkg::OFD_ACC_BANK, w[7:0]};
      else
         bank_addr = {ofd_pkg::OFD_ACC_HI_BANK, w[7:0]};
   endfunction : bank_addr

   ////////////////////////////////////////////////////////////////////////
   // Combinational field extraction

   always_comb begin
      logic [15:0] w;
      ofd_pkg::ofd_cls_t c;
      w = INSTR_WORD;
      c = cls_of(w);
      f_d = '0;
      second_d = 1'b0;
      if (second_q) begin
         c = cls_of(first_q);
         f_d.cls = c;
         // Second word: top nibble is always 1111 and ignored
         unique case (c)
            ofd_pkg::OFD_CLS_MOVFF: begin
               f_d.source_file_addr = first_q[11:0];
               f_d.destination_file_addr = w[11:0];
            end
            ofd_pkg::OFD_CLS_LFSR: begin
               f_d.ptr_sel = first_q[ofd_pkg::OFD_POS_PTR +: 2];
               f_d.literal = {8'h00, first_q[3:0], w[7:0]};
            end
            default: begin
               f_d.literal = {w[11:0], first_q[7:0]};
               f_d.branch_abs = {w[11:0], first_q[7:0]};
               f_d.shadow_save = (c == ofd_pkg::OFD_CLS_CALL)
                  && first_q[ofd_pkg::OFD_POS_CALL_S];
            end
         endcase
      end
      else begin
         f_d.cls = c;
         unique case (c)
            ofd_pkg::OFD_CLS_BYTE, ofd_pkg::OFD_CLS_BIT: begin
               f_d.file_addr = bank_addr(w, BANK_SELECT_REG);
               f_d.use_index = !w[ofd_pkg::OFD_POS_A] && EXT_SET_EN
                  && (w[7:0] <= ofd_pkg::OFD_IDX_LIMIT);
               if (c == ofd_pkg::OFD_CLS_BYTE) begin
                  f_d.to_file = w[ofd_pkg::OFD_POS_D];
                  f_d.to_accum = !w[ofd_pkg::OFD_POS_D];
               end
               else begin
                  f_d.bit_idx = w[ofd_pkg::OFD_POS_BIT +: 3];
                  f_d.bit_mask = 8'h01 << w[ofd_pkg::OFD_POS_BIT +: 3];
               end
            end
            ofd_pkg::OFD_CLS_LIT8:
               f_d.literal = {12'h000, w[7:0]};
            ofd_pkg::OFD_CLS_TBL_RD, ofd_pkg::OFD_CLS_TBL_WR:
               f_d.table_step_mode = ofd_pkg::ofd_tbl_step_t'(w[1:0]);
            ofd_pkg::OFD_CLS_BRA_REL:
               f_d.branch_disp = {{10{w[10]}}, w[10:0]};
            ofd_pkg::OFD_CLS_BCC_REL:
               f_d.branch_disp = {{13{w[7]}}, w[7:0]};
            ofd_pkg::OFD_CLS_RET:
               f_d.shadow_restore = w[ofd_pkg::OFD_POS_S];
            ofd_pkg::OFD_CLS_MOVFF, ofd_pkg::OFD_CLS_LFSR,
            ofd_pkg::OFD_CLS_GOTO, ofd_pkg::OFD_CLS_CALL: begin
               f_d.need_second = 1'b1;
               second_d = INSTR_VALID;
               f_d.ptr_sel = w[ofd_pkg::OFD_POS_PTR +: 2];
               f_d.source_file_addr = w[11:0];
            end
            default: f_d.cls = ofd_pkg::OFD_CLS_NONE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         second_q <= 1'b0;
         first_q <= ofd_pkg::OFD_RST_WORD;
      end
      else if (INSTR_VALID) begin
         second_q <= second_d;
         first_q <= INSTR_WORD;
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         fields_q <= '0;
         valid_q <= 1'b0;
      end
      else begin
         fields_q <= f_d;
         valid_q <= INSTR_VALID && !(f_d.need_second && !second_q);
      end
   end

   // Pointer and latch kept here so table stepping sees their widths
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         tptr_q <= '0;
         tlat_q <= '0;
      end
      else begin
         if (TBL_PTR_WR)
            tptr_q <= TBL_PTR_LOAD;
         else if (valid_q && (fields_q.cls == ofd_pkg::OFD_CLS_TBL_RD
                  || fields_q.cls == ofd_pkg::OFD_CLS_TBL_WR)) begin
            unique case (fields_q.table_step_mode)
               ofd_pkg::OFD_TBL_KEEP: tptr_q <= tptr_q;
               ofd_pkg::OFD_TBL_POST_DEC: tptr_q <= tptr_q - 21'h000001;
               ofd_pkg::OFD_TBL_POST_INC, ofd_pkg::OFD_TBL_PRE_INC:
                  tptr_q <= tptr_q + 21'h000001;
            endcase
         end
         if (TBL_LATCH_WR)
            tlat_q <= TBL_LATCH_LOAD;
      end
   end

   assign FIELDS = fields_q;
   assign FIELDS_VALID = valid_q;
   assign TABLE_POINTER = tptr_q;
   assign TABLE_LATCH = tlat_q;

endmodule : ofd_decode

//--- include/ofd_pkg.sv
package ofd_pkg;

   // Decoded instruction classes
   typedef enum logic [3:0] {
      OFD_CLS_NONE,
      OFD_CLS_BYTE,
      OFD_CLS_BIT,
      OFD_CLS_LIT8,
      OFD_CLS_MOVFF,
      OFD_CLS_LFSR,
      OFD_CLS_TBL_RD,
      OFD_CLS_TBL_WR,
      OFD_CLS_BRA_REL,
      OFD_CLS_BCC_REL,
      OFD_CLS_GOTO,
      OFD_CLS_CALL,
      OFD_CLS_RET
   } ofd_cls_t;

   // Table pointer step modes
   typedef enum logic [1:0] {
      OFD_TBL_KEEP,
      OFD_TBL_POST_INC,
      OFD_TBL_POST_DEC,
      OFD_TBL_PRE_INC
   } ofd_tbl_step_t;

   // Widths
   localparam int OFD_TABLE_POINTER_W = 21;
   localparam int OFD_TBLLAT_W = 8;
   localparam int OFD_FADDR_W = 12;
   localparam int OFD_LIT20_W = 20;

   // Field positions
   localparam int OFD_POS_A = 8;
   localparam int OFD_POS_D = 9;
   localparam int OFD_POS_BIT = 9;
   localparam int OFD_POS_S = 0;
   // Call keeps its fast bit clear of the low target byte
   localparam int OFD_POS_CALL_S = 8;
   localparam int OFD_POS_PTR = 4;

   // Reset values and limits
   localparam logic [7:0] OFD_IDX_LIMIT = 8'h5F;
   localparam logic [3:0] OFD_ACC_BANK = 4'h0;
   localparam logic [3:0] OFD_ACC_HI_BANK = 4'hF;
   localparam logic [7:0] OFD_ACC_SPLIT = 8'h60;
   localparam logic [15:0] OFD_RST_WORD = 16'h0000;

   typedef struct packed {
      ofd_cls_t cls;
      logic [11:0] file_addr;
      logic use_index;
      logic to_file;
      logic to_accum;
      logic [2:0] bit_idx;
      logic [7:0] bit_mask;
      logic [1:0] ptr_sel;
      logic [11:0] source_file_addr;
      logic [11:0] destination_file_addr;
      logic [19:0] literal;
      logic [20:0] branch_disp;
      logic [19:0] branch_abs;
      ofd_tbl_step_t table_step_mode;
      logic shadow_save;
      logic shadow_restore;
      logic need_second;
   } ofd_fields_t;

endpackage : ofd_pkg

//--- tb/ofd_decode_sva.sv
`timescale 1ns/10ps
module ofd_decode_sva (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Fetch and core state
   input wire logic [15:0] INSTR_WORD,
   input wire logic EXT_SET_EN,
   input wire logic [3:0] BANK_SELECT_REG,
   input wire logic TBL_PTR_WR,
   input wire logic [7:0] TBL_LATCH_LOAD,
   input wire logic TBL_LATCH_WR,
   // Decoded outputs
   input wire ofd_pkg::ofd_fields_t FIELDS,
   input wire logic FIELDS_VALID,
   input wire logic [20:0] TABLE_POINTER,
   input wire logic [7:0] TABLE_LATCH
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   wire byte_v = FIELDS_VALID && FIELDS.cls == ofd_pkg::OFD_CLS_BYTE;
   wire bit_v = FIELDS_VALID && FIELDS.cls == ofd_pkg::OFD_CLS_BIT;
   wire tbl_v = FIELDS_VALID && (FIELDS.cls == ofd_pkg::OFD_CLS_TBL_RD ||
      FIELDS.cls == ofd_pkg::OFD_CLS_TBL_WR);
   //////////////////////////////////////////////////////////////
   AST_BANK: assert property (byte_v && $past(INSTR_WORD[8]) |->
      FIELDS.file_addr == {$past(BANK_SELECT_REG), $past(INSTR_WORD[7:0])})
      else $error("banked address wrong");
   AST_ACCESS: assert property (byte_v && !$past(INSTR_WORD[8]) |->
      FIELDS.file_addr == {($past(INSTR_WORD[7:0]) < 8'h60) ? 4'h0 : 4'hF,
      $past(INSTR_WORD[7:0])}) else $error("access address wrong");
   AST_DEST: assert property (byte_v |->
      FIELDS.to_file == $past(INSTR_WORD[9]) &&
      FIELDS.to_accum == !$past(INSTR_WORD[9])) else $error("dest wrong");
   AST_INDEX: assert property (byte_v || bit_v |->
      FIELDS.use_index == (!$past(INSTR_WORD[8]) && $past(EXT_SET_EN) &&
      $past(INSTR_WORD[7:0]) <= 8'h5F)) else $error("index mode wrong");
   AST_BIT: assert property (bit_v |->
      FIELDS.bit_idx == $past(INSTR_WORD[11:9]) &&
      FIELDS.bit_mask == 8'h01 << FIELDS.bit_idx) else $error("bit wrong");
   AST_LIT8: assert property (
      FIELDS_VALID && FIELDS.cls == ofd_pkg::OFD_CLS_LIT8 |->
      FIELDS.literal == {12'h000, $past(INSTR_WORD[7:0])})
      else $error("literal wrong");
   AST_STEP: assert property (tbl_v |->
      FIELDS.table_step_mode == $past(INSTR_WORD[1:0]))
      else $error("step mode wrong");
   AST_INC: assert property (tbl_v && !TBL_PTR_WR &&
      FIELDS.table_step_mode == ofd_pkg::OFD_TBL_POST_INC |=>
      TABLE_POINTER == $past(TABLE_POINTER) + 21'h1) else $error("no step");
   AST_LATCH: assert property (TBL_LATCH_WR |=>
      TABLE_LATCH == $past(TBL_LATCH_LOAD)) else $error("latch not loaded");
   AST_RESTORE: assert property (
      FIELDS_VALID && FIELDS.cls == ofd_pkg::OFD_CLS_RET |->
      FIELDS.shadow_restore == $past(INSTR_WORD[0]))
      else $error("restore wrong");
   COV_IDX: cover property (byte_v && FIELDS.use_index);
   COV_MOVE: cover property (FIELDS.cls == ofd_pkg::OFD_CLS_MOVFF);
   COV_DEC: cover property ((tbl_v &&
      FIELDS.table_step_mode == ofd_pkg::OFD_TBL_POST_DEC) ##1
      (TABLE_POINTER == 21'h1FFFFF));
endmodule : ofd_decode_sva
bind ofd_decode ofd_decode_sva ofd_decode_sva_i (.SYS_CLK, .RST,
   .INSTR_WORD, .EXT_SET_EN, .BANK_SELECT_REG, .TBL_PTR_WR,
   .TBL_LATCH_LOAD, .TBL_LATCH_WR, .FIELDS, .FIELDS_VALID,
   .TABLE_POINTER, .TABLE_LATCH);

//--- tb/opcode_operand_field_decode_tb_top.sv
`timescale 1ns/10ps
module opcode_operand_field_decode_tb_top;
   typedef struct packed {
      logic [15:0] w;
      logic ext;
      ofd_pkg::ofd_cls_t cls;
      logic [11:0] fa;
      logic tf;
      logic ui;
   } ofd_row_t;
   localparam ofd_pkg::ofd_cls_t by_c = ofd_pkg::OFD_CLS_BYTE;
   logic SYS_CLK, RST, INSTR_VALID, EXT_SET_EN, TBL_PTR_WR, TBL_LATCH_WR;
   logic [15:0] INSTR_WORD;
   logic [3:0] BANK_SELECT_REG;
   logic [20:0] TBL_PTR_LOAD, TABLE_POINTER;
   logic [7:0] TBL_LATCH_LOAD, TABLE_LATCH;
   logic FIELDS_VALID;
   ofd_pkg::ofd_fields_t FIELDS;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   // Bank select stays 3 in every row
   ofd_row_t rows [6] = '{'{16'h2455, 1'h0, by_c, 12'h055, 1'h0, 1'h0},
      '{16'h2455, 1'h1, by_c, 12'h055, 1'h0, 1'h1},
      '{16'h2760, 1'h1, by_c, 12'h360, 1'h1, 1'h0},
      '{16'h2460, 1'h1, by_c, 12'hF60, 1'h0, 1'h0},
      '{16'h1A5F, 1'h1, by_c, 12'h05F, 1'h1, 1'h1},
      '{16'h8E05, 1'h1, ofd_pkg::OFD_CLS_BIT, 12'h005, 1'h0, 1'h1}};
   ofd_decode ofd_decode_i (.SYS_CLK, .RST, .INSTR_WORD, .INSTR_VALID,
      .EXT_SET_EN, .BANK_SELECT_REG, .TBL_PTR_LOAD, .TBL_PTR_WR,
      .TBL_LATCH_LOAD, .TBL_LATCH_WR, .FIELDS, .FIELDS_VALID,
      .TABLE_POINTER, .TABLE_LATCH);
   //////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (exp !== got) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   // A dead cycle first, so valid is never set twice in one step
   task automatic put(logic [15:0] w);
      @(negedge SYS_CLK);
      INSTR_WORD = w;
      INSTR_VALID = 1'h1;
      @(negedge SYS_CLK);
      INSTR_VALID = 1'h0;
   endtask : put
   task automatic final_report;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report
   initial begin
      SYS_CLK = 1'h0;
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 1000) begin
         n_fail++;
         final_report();
      end
   end
   //////////////////////////////////////////////////////////////
   initial begin
      {RST, INSTR_VALID, EXT_SET_EN, TBL_PTR_WR, TBL_LATCH_WR} = 5'h10;
      INSTR_WORD = 16'h0000;
      BANK_SELECT_REG = 4'h3;
      TBL_PTR_LOAD = 21'h000000;
      TBL_LATCH_LOAD = 8'h00;
      repeat (6) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      RST = 1'h0;
      chk("ptr_rst", 32'h0, TABLE_POINTER);
      foreach (rows[i]) begin
         EXT_SET_EN = rows[i].ext;
         put(rows[i].w);
         chk("valid", 32'h1, FIELDS_VALID);
         chk("cls", rows[i].cls, FIELDS.cls);
         chk("file_addr", rows[i].fa, FIELDS.file_addr);
         chk("use_index", rows[i].ui, FIELDS.use_index);
         if (rows[i].cls == by_c) begin
            chk("to_file", rows[i].tf, FIELDS.to_file);
            chk("to_accum", !rows[i].tf, FIELDS.to_accum);
         end
      end
      put(16'h0F3C);
      chk("lit8", 32'h3C, FIELDS.literal);
      put(16'hEE2A);
      put(16'hF0BC);
      chk("ptr_sel", 32'h2, FIELDS.ptr_sel);
      chk("lit12", 32'hABC, FIELDS.literal);
      for (int j = 0; j < 2; j++) begin
         put(16'hC123);
         chk("first_word", 32'h0, FIELDS_VALID);
         put(j ? 16'h0456 : 16'hF456);
         chk("src", 32'h123, FIELDS.source_file_addr);
         chk("dst", 32'h456, FIELDS.destination_file_addr);
         put(16'hEC34 | {7'h00, j[0], 8'h00});
         put(16'hF567);
         chk("target", 32'h56734, FIELDS.branch_abs);
         chk("shadow", j[0], FIELDS.shadow_save);
      end
      put(16'hEF35);
      put(16'hF567);
      chk("goto", ofd_pkg::OFD_CLS_GOTO, FIELDS.cls);
      chk("lit20", 32'h56735, FIELDS.literal);
      chk("goto_save", 32'h0, FIELDS.shadow_save);
      put(16'hD402);
      chk("bra_disp", 32'h1FFC02, FIELDS.branch_disp);
      put(16'hE180);
      chk("bcc_disp", 32'h1FFF80, FIELDS.branch_disp);
      for (int k = 0; k < 4; k++) begin
         put(16'h0010 + k[15:0]);
         chk("ret_cls", ofd_pkg::OFD_CLS_RET, FIELDS.cls);
         chk("restore", k[0], FIELDS.shadow_restore);
      end
      put(16'h9A05);
      chk("bit_idx", 32'h5, FIELDS.bit_idx);
      chk("bit_mask", 32'h20, FIELDS.bit_mask);
      for (int i = 0; i < 8; i++) begin
         TBL_PTR_WR = 1'h1;
         @(negedge SYS_CLK);
         TBL_PTR_WR = 1'h0;
         put(16'h0008 + i[15:0]);
         chk("mode", i[1:0], FIELDS.table_step_mode);
         @(negedge SYS_CLK);
         chk("ptr", (i[1:0] == 2'h2) ? 21'h1FFFFF : {20'h0, i[1:0] != 2'h0},
            TABLE_POINTER);
      end
      TBL_LATCH_LOAD = 8'hA5;
      TBL_LATCH_WR = 1'h1;
      TBL_PTR_LOAD = 21'h0ABCDE;
      TBL_PTR_WR = 1'h1;
      @(negedge SYS_CLK);
      TBL_LATCH_WR = 1'h0;
      TBL_PTR_WR = 1'h0;
      chk("latch", 32'hA5, TABLE_LATCH);
      chk("ptr_load", 32'h0ABCDE, TABLE_POINTER);
      RST = 1'h1;
      @(negedge SYS_CLK);
      RST = 1'h0;
      chk("latch_rst", 32'h0, TABLE_LATCH);
      chk("ptr_rst2", 32'h0, TABLE_POINTER);
      chk("valid_rst", 32'h0, FIELDS_VALID);
      chk("cls_rst", ofd_pkg::OFD_CLS_NONE, FIELDS.cls);
      final_report();
   end
endmodule : opcode_operand_field_decode_tb_top
